// >>> verilog/bip_port.sv
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Bidirectional I/O ports with Avalon-MM register access
module bip_port
	import bip_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Pins, flattened port-major
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_i,
	output logic [NUM_PORTS*PORT_W-1:0] pin_o,
	output logic [NUM_PORTS*PORT_W-1:0] pin_oe_o,
	output logic [NUM_PORTS*PORT_W-1:0] pullup_en_o,
	// Alternate function overrides per pin
	input wire logic [NUM_PORTS*PORT_W-1:0] alt_dir_en_i,
	input wire logic [NUM_PORTS*PORT_W-1:0] alt_dir_val_i,
	input wire logic [NUM_PORTS*PORT_W-1:0] alt_out_en_i,
	input wire logic [NUM_PORTS*PORT_W-1:0] alt_out_val_i,
	input wire logic [NUM_PORTS*PORT_W-1:0] alt_pu_en_i,
	input wire logic [NUM_PORTS*PORT_W-1:0] alt_pu_val_i
);
	localparam int NPIN = NUM_PORTS*PORT_W;

	// All module state
	typedef struct packed {
		logic [NPIN-1:0] drive_value_latch_r; // Drive or pull-up bits
		logic [NPIN-1:0] direction_latch_r; // One means output
		logic [BYTE_W-1:0] special_function_control_r;
		logic ack_r; // Access answered this cycle
		logic [31:0] rdata_r;
	} bip_state_s;
	bip_state_s st_r;
	bip_state_s st_nxt;

	logic [NPIN-1:0] input_level_sample; // Synchronized pin levels
	logic global_pullup_off;
	logic [NPIN-1:0] eff_dir;
	logic [NPIN-1:0] eff_out;
	logic [NPIN-1:0] eff_pu;

	// Decode a word index into port and location; valid flag returned
	function automatic logic idx_decode(input logic [IDX_W-1:0] idx,
		output logic [1:0] port, output logic [1:0] loc);
		logic [IDX_W-1:0] rem;
		rem = idx;
		port = 2'h0;
		loc = 2'h0;
		idx_decode = 1'b0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (rem < IDX_W'(LOCS_PER_PORT) && !idx_decode) begin
				port = 2'(p);
				loc = rem[1:0];
				idx_decode = 1'b1;
			end else if (!idx_decode) begin
				rem = rem - IDX_W'(LOCS_PER_PORT);
			end
		end
	endfunction : idx_decode

	// Pin levels cross into the core clock before software sees them
	bip_sync #(.W(NPIN)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(pin_i),
		.q_o(input_level_sample)
	);

	assign global_pullup_off =
		st_r.special_function_control_r[SFC_PULLUP_OFF_BIT];

	// Pad control: overrides act per pin, so other pins stay plain I/O
	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			eff_dir[i] = alt_dir_en_i[i] ? alt_dir_val_i[i]
				: st_r.direction_latch_r[i];
			eff_out[i] = alt_out_en_i[i] ? alt_out_val_i[i]
				: st_r.drive_value_latch_r[i];
			// Per-pin pull-up: input with drive bit set
			eff_pu[i] = alt_pu_en_i[i] ? alt_pu_val_i[i]
				: (!eff_dir[i] && st_r.drive_value_latch_r[i]);
			if (global_pullup_off) begin
				eff_pu[i] = 1'b0;
			end
		end
	end

	assign pin_o = eff_out;
	assign pin_oe_o = eff_dir;
	assign pullup_en_o = eff_pu;
	assign avs_readdata_o = st_r.rdata_r;
	// Every access waits exactly one cycle for its registered answer
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_r.ack_r;

	// Next state: register access and single-bit commands
	always_comb begin
		logic [1:0] port;
		logic [1:0] loc;
		logic hit;
		logic [IDX_W-1:0] idx;
		logic [BYTE_W-1:0] wb;
		int base;
		int bp;
		port = 2'h0;
		loc = 2'h0;
		hit = 1'b0;
		idx = avs_address_i[ADDR_W-1:IDX_LSB];
		wb = avs_writedata_i[BYTE_W-1:0];
		base = 0;
		bp = 0;
		st_nxt = st_r;
		st_nxt.ack_r = 1'b0;
		hit = idx_decode(idx, port, loc);
		base = int'(port) * PORT_W;
		// Release the answer flag after one handshake
		if ((avs_read_i || avs_write_i) && !st_r.ack_r) begin
			st_nxt.ack_r = 1'b1;
			st_nxt.rdata_r = UNMAPPED_RD;
			if (hit && loc == LOC_INPUT) begin
				st_nxt.rdata_r[BYTE_W-1:0] =
					input_level_sample[base +: PORT_W];
			end else if (hit && loc == LOC_DIRECTION) begin
				st_nxt.rdata_r[BYTE_W-1:0] =
					st_r.direction_latch_r[base +: PORT_W];
			end else if (hit && loc == LOC_DRIVE) begin
				st_nxt.rdata_r[BYTE_W-1:0] =
					st_r.drive_value_latch_r[base +: PORT_W];
			end else if (idx == IDX_SPECIAL) begin
				st_nxt.rdata_r[BYTE_W-1:0] =
					st_r.special_function_control_r;
			end
			if (avs_read_i) begin
				// Read data only
			end else if (!avs_byteenable_i[0]) begin
				// Low lane not enabled: nothing stored
			end else if (hit && loc == LOC_INPUT) begin
				// Pin-level location ignores writes
			end else if (hit && loc == LOC_DIRECTION) begin
				st_nxt.direction_latch_r[base +: PORT_W] = wb;
			end else if (hit && loc == LOC_DRIVE) begin
				st_nxt.drive_value_latch_r[base +: PORT_W] = wb;
			end else if (idx == IDX_SPECIAL) begin
				st_nxt.special_function_control_r = wb;
			end else if (idx == IDX_BITOP) begin
				// Touch exactly one bit, leaving all others intact
				bp = int'(wb[BOP_PORT_LSB +: 2]) * PORT_W
					+ int'(wb[BOP_PIN_LSB +: 3]);
				if (wb[BOP_TGT_BIT]) begin
					st_nxt.drive_value_latch_r[bp] = wb[BOP_VAL_BIT];
				end else begin
					st_nxt.direction_latch_r[bp] = wb[BOP_VAL_BIT];
				end
			end
		end
	end

	// State register; reset leaves all non-overridden pins inputs without pull-up
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r.drive_value_latch_r <= '0;
			st_r.direction_latch_r <= '0;
			st_r.special_function_control_r <= SFC_RST;
			st_r.ack_r <= 1'b0;
			st_r.rdata_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : bip_port
`default_nettype wire

// >>> verilog/bip_pkg.sv
package bip_pkg;
	// Port geometry
	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 8;
	localparam int BYTE_W = 8;
	// Word index layout: port number times three plus location
	localparam int LOCS_PER_PORT = 3;
	localparam logic [1:0] LOC_INPUT = 2'h0;
	localparam logic [1:0] LOC_DIRECTION = 2'h1;
	localparam logic [1:0] LOC_DRIVE = 2'h2;
	// Word index of the special function control register
	localparam logic [3:0] IDX_SPECIAL = 4'hc;
	// Word index of the single-bit set/clear command register
	localparam logic [3:0] IDX_BITOP = 4'hd;
	localparam int ADDR_W = 6;
	localparam int IDX_W = 4;
	// Byte address of a word index
	localparam int IDX_LSB = 2;
	// Special function control: global pull-up off position
	localparam int SFC_PULLUP_OFF_BIT = 2;
	// Bit command layout: bit[2:0] pin, bit[4:3] port,
	// bit[5] target (1 drive, 0 direction), bit[6] value
	localparam int BOP_PIN_LSB = 0;
	localparam int BOP_PORT_LSB = 3;
	localparam int BOP_TGT_BIT = 5;
	localparam int BOP_VAL_BIT = 6;
	// Reset values
	localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
	localparam logic [BYTE_W-1:0] SFC_RST = 8'h00;
	// Answer for unmapped addresses
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage : bip_pkg

// >>> verilog/bip_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchronizer for a vector of pin levels
module bip_sync
	import bip_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// First stage is read only by the second stage
	typedef struct packed {
		logic [W-1:0] meta_r;
		logic [W-1:0] q_r;
	} bip_sync_s;
	bip_sync_s st_r;
	bip_sync_s st_nxt;

	// Next state: shift the pins through two stages
	always_comb begin
		st_nxt = st_r;
		st_nxt.meta_r = d_i;
		st_nxt.q_r = st_r.meta_r;
	end

	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q_r;
endmodule : bip_sync
`default_nettype wire

// >>> tb/bip_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on bus timing, latch updates and pin control
module bip_port_monitor
	import bip_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [31:0] pin_o,
	input wire logic [31:0] pin_oe_o,
	input wire logic [31:0] pullup_en_o,
	input wire logic [31:0] alt_dir_en_i,
	input wire logic [31:0] alt_out_en_i,
	input wire logic [31:0] alt_pu_en_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// One-hot of the pin a bit command addresses
	wire logic [31:0] m = 32'h1 << avs_writedata_i[4:0];
	// Bit command accepted, t picks drive or direction
	sequence s_bop(t);
		avs_write_i && !avs_waitrequest_o
		&& avs_address_i[5:2] == IDX_BITOP && avs_writedata_i[5] == t;
	endsequence
	ans_next_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
	idle_nowait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o) else $error("idle wait");
	rst_input_a: assert property ($fell(rst_i) |-> (pin_oe_o & ~alt_dir_en_i) == 0 && (pullup_en_o & ~alt_pu_en_i) == 0) else $error("reset state");
	pu_off_out_a: assert property ((pin_oe_o & pullup_en_o & ~alt_pu_en_i) == 0) else $error("pull-up on output");
	dir_bit_a: assert property (s_bop(0) ##0 (alt_dir_en_i == 0) |=> ((pin_oe_o ^ $past(pin_oe_o)) & ~$past(m)) == 0 && pin_oe_o[$past(avs_writedata_i[4:0])] == $past(avs_writedata_i[6])) else $error("direction bit");
	drv_bit_a: assert property (s_bop(1) ##0 (alt_out_en_i == 0) |=> ((pin_o ^ $past(pin_o)) & ~$past(m)) == 0) else $error("drive bit");
	rd_upper_a: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 0) else $error("read upper");
	rd_hold_a: assert property (!(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o)) else $error("read data moved");
endmodule : bip_port_monitor
bind bip_port bip_port_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o),
	.alt_dir_en_i(alt_dir_en_i), .alt_out_en_i(alt_out_en_i),
	.alt_pu_en_i(alt_pu_en_i));
`default_nettype wire

// >>> tb/bip_pins.sv
`timescale 1ns/100ps
`default_nettype none
// Board side: drivers, pull-ups, an external low load, floating pins
module bip_pins (
	input wire logic clk_i,
	input wire logic [31:0] drv_i,
	input wire logic [31:0] oe_i,
	input wire logic [31:0] pu_i,
	input wire logic [31:0] lo_i,
	output logic [31:0] pin_o
);
	// Floating pins toggle so no read can lean on a settled unknown
	logic [31:0] fl = 32'h0;
	always @(posedge clk_i) fl <= ~fl;
	// Driver wins, then external low, then pull-up, else floating
	assign pin_o = (oe_i & drv_i) | (~oe_i & ~lo_i & (pu_i | fl));
endmodule : bip_pins
`default_nettype wire

// >>> tb/bip_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bip_port_tb
	import bip_pkg::*;
;
	logic clk_i = 0, rst_i = 1, rd = 0, wr = 0;
	logic [5:0] ad = 0;
	logic [31:0] wd = 0, alt = 0, lo = 0, rdat;
	wire logic [31:0] rdo, pin, po, poe, pu;
	wire logic wt;
	int fails = 0, comparisons = 0;
	// Rows: index, write byte, expected read back
	logic [19:0] rows [5] = '{20'h10f0f, 20'h2c3c3, 20'hba5a5,
		20'ha5a5a, 20'heff00};
	bip_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(ad),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
		.avs_waitrequest_o(wt), .pin_i(pin), .pin_o(po), .pin_oe_o(poe),
		.pullup_en_o(pu), .alt_dir_en_i(alt), .alt_dir_val_i(alt),
		.alt_out_en_i(alt), .alt_out_val_i(alt), .alt_pu_en_i(32'h0),
		.alt_pu_val_i(32'h0));
	bip_pins i_pins (.clk_i(clk_i), .drv_i(po), .oe_i(poe), .pu_i(pu),
		.lo_i(lo), .pin_o(pin));
	initial forever #10 clk_i = ~clk_i;
	task ck(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, s, e);
		end
	endtask : ck
	task summarize;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Bus cycle: called just after a rising edge; holds the request until
	// waitrequest is sampled low at a rising edge, takes data there, then
	// lets one idle edge pass so the next call never re-raises in one step
	task acc(input logic w, input logic [3:0] i, input logic [7:0] d);
		wr <= w;
		rd <= !w;
		ad <= {i, 2'h0};
		wd <= {24'h0, d};
		do @(posedge clk_i); while (wt !== 1'b0);
		rdat = rdo;
		wr <= 0;
		rd <= 0;
		@(posedge clk_i);
	endtask : acc
	initial begin
		#200000;
		fails++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		foreach (rows[k]) begin
			acc(1, rows[k][19:16], rows[k][15:8]);
			acc(0, rows[k][19:16], 0);
			ck(rdat, rows[k][7:0]);
		end
		ck(poe[7:0], 8'h0f);
		ck(pu[7:0], 8'hc0);
		acc(0, 0, 0);
		ck(rdat & 32'hcf, 32'hc3);
		acc(1, 12, 8'h04);
		ck(pu, 0);
		acc(1, 12, 0);
		acc(1, 13, 8'h45);
		acc(0, 1, 0);
		ck(rdat, 8'h2f);
		acc(1, 13, 8'h20);
		acc(0, 2, 0);
		ck(rdat, 8'hc2);
		// Pin 7 pulled low outside; first read still sees old level
		@(posedge clk_i);
		lo <= 32'h80;
		acc(0, 0, 0);
		ck(rdat[7], 1);
		acc(0, 0, 0);
		ck(rdat[7], 0);
		alt <= 32'h100;
		acc(1, 4, 8'hf0);
		ck(poe[15:8], 8'hf1);
		ck(po[8], 1);
		alt <= 0;
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		ck(poe, 0);
		ck(pu, 0);
		acc(0, 11, 0);
		ck(rdat, 0);
		summarize();
	end
endmodule : bip_port_tb
`default_nettype wire
